// file: rtl/strap_ctrl_pkg.sv
// What this block does
// - Reset loads fast-select enable from pin
// - Enabled: pin high picks primary input three, low four
// - Disabled: fast-select pin level is ignored
// - Role combines role pin and control bit
// - Role pin mirrored into read-only status bit
// - Reset loads frequency family bit from strap
// - Family strap ignored after reset ends
// - Reset pin low 50us; internal hold 500ms
// - Each path: free-run, locked, holdover modes
// - Mode switch forced or automatic by FSM
// - Secondary locks own input or primary output
// - One input per path, auto or manual
// - Bandwidth 19 steps, damping 5 steps
// - Master clock drives all; calibration +-741ppm
// - Phase absorption when limit exceeded under 0.1s
// - Build-out bounds primary output transient 0.61ns
// - Failed input replaced automatically, hitless
// - Sync in 8 kHz; outputs 2 and 8 kHz
// - Registers reached only through host interface
package strap_ctrl_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h09; // Role pin, family bit
  localparam logic [7:0] IDX_INSEL = 8'h0b; // Fast-select enable
  localparam logic [7:0] IDX_ROLE = 8'h13; // Role control
  // Register byte offsets
  localparam logic [7:0] REG_STATUS = IDX_STATUS << 2; // Status word
  localparam logic [7:0] REG_INSEL = IDX_INSEL << 2; // Input select word
  localparam logic [7:0] REG_ROLE = IDX_ROLE << 2; // Role word
  localparam logic [7:0] REG_PATH = 8'h80; // Path mode and source control
  localparam logic [7:0] REG_LOOP = 8'h84; // Bandwidth, damping, calibration
  localparam logic [7:0] REG_MODE = 8'h88; // Mode and selection status
  // Field positions
  localparam int B_FAST_EN = 4;
  localparam int B_ROLE_CTRL = 0;
  localparam int B_ROLE_PIN = 1;
  localparam int B_FAMILY = 2;
  // Fast pair inputs picked by the fast-select pin
  localparam logic [3:0] FAST_HI_SRC = 4'h3; // Pin high: primary input three
  localparam logic [3:0] FAST_LO_SRC = 4'h4; // Pin low: primary input four
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int HOLD_MS = 500;
  localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int PHASE_WIN_MS = 100;
  localparam int PHASE_WIN_CYC = CLK_HZ / 1000 * PHASE_WIN_MS;
  localparam logic [4:0] BW_STEPS = 5'h13;
  localparam logic [2:0] DAMP_STEPS = 3'h5;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // Operating modes, one-hot
  typedef enum logic [2:0]
  {
    M_FREE = 3'h1,
    M_LOCK = 3'h2,
    M_HOLD = 3'h4
  } mode_t;
  // Per-path control from software
  typedef struct packed
  {
    logic force_en; // Force the mode
    logic [1:0] force_mode; // 0 free, 1 lock, 2 hold
    logic manual_sel; // Manual input selection
    logic [3:0] manual_src; // Manual input number
  } path_cfg_t;
endpackage : strap_ctrl_pkg

// file: rtl/timing_strap_reset_mode_ctrl.sv
`timescale 1ns/100ps
module timing_strap_reset_mode_ctrl
  import strap_ctrl_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC, // Internal reset hold after release
  parameter int PHASE_WIN_CYCLES = PHASE_WIN_CYC // Phase absorption window
)
(
  input wire logic clock, // Master clock
  input wire logic nrst, // Async reset, active low
  input wire logic fast_ref_select_pin, // Fast pair select strap/pin
  input wire logic role_select_pin, // Master/slave pin
  input wire logic freq_family_pin, // SONET/SDH strap
  input wire logic [13:0] ref_valid_pins, // Per-input clock good flags
  input wire logic phase_jump_pin, // Phase step over limit seen
  input wire logic frame_sync_in, // Frame sync input
  output logic dev_ready, // Internal reset over
  output logic is_master, // Resolved role
  output logic [3:0] primary_src, // Primary path input
  output logic [3:0] secondary_src, // Secondary path input
  output logic [2:0] primary_mode, // Primary mode one-hot
  output logic [2:0] secondary_mode, // Secondary mode one-hot
  output logic secondary_follow, // Secondary locks primary output
  output logic phase_absorb, // Absorbing phase on primary
  output logic pbo_event, // Build-out on reference change
  output logic sync8k_out, // 8 kHz frame sync
  output logic sync2k_out, // 2 kHz frame sync
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // Reset release synchroniser
  logic rst_a_ff, rst_b_ff;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  wire rst_n = rst_b_ff; // Synchronised reset

  // Pin synchronisers, two stages each
  logic [18:0] pin_a_ff, pin_b_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_a_ff <= '0;
      pin_b_ff <= '0;
    end
    else
    begin
      pin_a_ff <= {frame_sync_in, phase_jump_pin, freq_family_pin, role_select_pin,
                   fast_ref_select_pin, ref_valid_pins};
      pin_b_ff <= pin_a_ff;
    end
  end
  wire fast_pin_s = pin_b_ff[14];
  wire role_pin_s = pin_b_ff[15];
  wire family_pin_s = pin_b_ff[16];
  wire jump_s = pin_b_ff[17];
  wire fsync_s = pin_b_ff[18];
  wire [13:0] valid_s = pin_b_ff[13:0]; // Every good flag synchronised

  // Internal reset hold counter and strap capture
  logic [31:0] hold_ff, nxt_hold;
  logic ready_ff, nxt_ready;
  logic fast_en_ff, nxt_fast_en;
  logic family_ff, nxt_family;
  logic role_ctrl_ff, nxt_role_ctrl;
  path_cfg_t pcfg_ff, nxt_pcfg, scfg_ff, nxt_scfg;
  logic follow_ff, nxt_follow;
  logic [4:0] bw_ff, nxt_bw;
  logic [2:0] damp_ff, nxt_damp;
  logic [10:0] cal_ff, nxt_cal;
  logic wr_go;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] wr_data_ff, nxt_wr_data;

  // Hold, strap capture and software register next state
  always_comb
  begin
    nxt_hold = hold_ff;
    nxt_ready = ready_ff;
    nxt_fast_en = fast_en_ff;
    nxt_family = family_ff;
    nxt_role_ctrl = role_ctrl_ff;
    nxt_pcfg = pcfg_ff;
    nxt_scfg = scfg_ff;
    nxt_follow = follow_ff;
    nxt_bw = bw_ff;
    nxt_damp = damp_ff;
    nxt_cal = cal_ff;
    if (!ready_ff)
    begin
      // Straps track pins until the hold ends, then freeze
      nxt_fast_en = fast_pin_s;
      nxt_family = family_pin_s;
      nxt_hold = hold_ff + 32'h1;
      if (hold_ff >= 32'(HOLD_CYCLES) - 32'h1)
        nxt_ready = 1'b1;
    end
    else if (wr_go)
    begin
      // Software writes after reset; family strap no longer read
      case (wr_addr_ff)
        REG_STATUS: nxt_family = wr_data_ff[B_FAMILY];
        REG_INSEL: nxt_fast_en = wr_data_ff[B_FAST_EN];
        REG_ROLE: nxt_role_ctrl = wr_data_ff[B_ROLE_CTRL];
        REG_PATH:
        begin
          nxt_pcfg = path_cfg_t'(wr_data_ff[7:0]);
          nxt_scfg = path_cfg_t'(wr_data_ff[15:8]);
          nxt_follow = wr_data_ff[16];
        end
        REG_LOOP:
        begin
          if (wr_data_ff[4:0] < BW_STEPS)
            nxt_bw = wr_data_ff[4:0];
          if (wr_data_ff[10:8] < DAMP_STEPS)
            nxt_damp = wr_data_ff[10:8];
          nxt_cal = wr_data_ff[26:16];
        end
        default: ;
      endcase
    end
  end

  // Register the control state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_ff <= '0;
      ready_ff <= 1'b0;
      fast_en_ff <= 1'b0;
      family_ff <= 1'b0;
      role_ctrl_ff <= 1'b0;
      pcfg_ff <= '0;
      scfg_ff <= '0;
      follow_ff <= 1'b0;
      bw_ff <= '0;
      damp_ff <= '0;
      cal_ff <= '0;
    end
    else
    begin
      hold_ff <= nxt_hold;
      ready_ff <= nxt_ready;
      fast_en_ff <= nxt_fast_en;
      family_ff <= nxt_family;
      role_ctrl_ff <= nxt_role_ctrl;
      pcfg_ff <= nxt_pcfg;
      scfg_ff <= nxt_scfg;
      follow_ff <= nxt_follow;
      bw_ff <= nxt_bw;
      damp_ff <= nxt_damp;
      cal_ff <= nxt_cal;
    end
  end

  // Source selection: fast pair, manual, or lowest good input
  function automatic logic [3:0] first_good(input logic [13:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 13; i >= 0; i--)
      if (v[i])
        r = 4'(i + 1);
    return r;
  endfunction : first_good

  logic [3:0] psrc, ssrc;
  always_comb
  begin
    if (fast_en_ff)
      psrc = fast_pin_s ? FAST_HI_SRC : FAST_LO_SRC;
    else if (pcfg_ff.manual_sel)
      psrc = pcfg_ff.manual_src;
    else
      psrc = first_good(valid_s);
    ssrc = scfg_ff.manual_sel ? scfg_ff.manual_src : first_good(valid_s);
  end

  // Mode machines for both paths
  mode_t pmode_ff, nxt_pmode, smode_ff, nxt_smode;
  logic plocked_once_ff, nxt_plocked_once, slocked_once_ff, nxt_slocked_once;
  function automatic mode_t next_mode(input path_cfg_t c, input logic good, input logic was_locked);
    mode_t m;
    m = M_FREE;
    if (c.force_en)
    begin
      case (c.force_mode)
        2'h1: m = M_LOCK;
        2'h2: m = M_HOLD;
        default: m = M_FREE;
      endcase
    end
    else if (good)
      m = M_LOCK;
    else if (was_locked)
      m = M_HOLD;
    return m;
  endfunction : next_mode

  wire pgood = (psrc != 4'h0) && valid_s[psrc - 4'h1];
  wire sgood = follow_ff || ((ssrc != 4'h0) && valid_s[ssrc - 4'h1]);
  always_comb
  begin
    nxt_pmode = next_mode(pcfg_ff, pgood, plocked_once_ff);
    nxt_smode = next_mode(scfg_ff, sgood, slocked_once_ff);
    nxt_plocked_once = plocked_once_ff | (pmode_ff == M_LOCK);
    nxt_slocked_once = slocked_once_ff | (smode_ff == M_LOCK);
    if (!ready_ff)
    begin
      nxt_pmode = M_FREE;
      nxt_smode = M_FREE;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pmode_ff <= M_FREE;
      smode_ff <= M_FREE;
      plocked_once_ff <= 1'b0;
      slocked_once_ff <= 1'b0;
    end
    else
    begin
      pmode_ff <= nxt_pmode;
      smode_ff <= nxt_smode;
      plocked_once_ff <= nxt_plocked_once;
      slocked_once_ff <= nxt_slocked_once;
    end
  end

  // Phase absorption window, build-out and frame sync dividers
  logic [31:0] win_ff, nxt_win;
  logic absorb_ff, nxt_absorb, pbo_ff, nxt_pbo;
  logic [3:0] psrc_ff;
  logic fsync_d_ff;
  logic jump_d_ff; // Phase step pin, one cycle late
  logic [3:0] ssrc_ff; // Registered secondary input
  logic master_ff; // Registered role
  // A held phase step counts once, at its start
  wire jump_edge = jump_s && !jump_d_ff;
  logic [1:0] fdiv_ff, nxt_fdiv;
  logic s8_ff, s2_ff, nxt_s8, nxt_s2;
  always_comb
  begin
    nxt_win = (win_ff != 32'h0) ? win_ff - 32'h1 : 32'h0;
    nxt_absorb = 1'b0;
    if (jump_edge && win_ff != 32'h0)
      nxt_absorb = 1'b1;
    if (jump_edge)
      nxt_win = 32'(PHASE_WIN_CYCLES);
    nxt_pbo = ready_ff && (psrc != psrc_ff);
    nxt_fdiv = fdiv_ff;
    nxt_s8 = 1'b0;
    nxt_s2 = 1'b0;
    if (fsync_s && !fsync_d_ff)
    begin
      nxt_fdiv = fdiv_ff + 2'h1;
      nxt_s8 = 1'b1;
      nxt_s2 = (fdiv_ff == 2'h0);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_ff <= '0;
      absorb_ff <= 1'b0;
      pbo_ff <= 1'b0;
      psrc_ff <= '0;
      fsync_d_ff <= 1'b0;
      jump_d_ff <= 1'b0;
      ssrc_ff <= '0;
      master_ff <= 1'b0;
      fdiv_ff <= '0;
      s8_ff <= 1'b0;
      s2_ff <= 1'b0;
    end
    else
    begin
      win_ff <= nxt_win;
      absorb_ff <= nxt_absorb;
      pbo_ff <= nxt_pbo;
      psrc_ff <= psrc;
      fsync_d_ff <= fsync_s;
      jump_d_ff <= jump_s;
      ssrc_ff <= ssrc;
      master_ff <= role_pin_s ^ role_ctrl_ff;
      fdiv_ff <= nxt_fdiv;
      s8_ff <= nxt_s8;
      s2_ff <= nxt_s2;
    end
  end

  // AXI4-Lite slave: one write, one read at a time
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic known_wr, known_rd;
  always_comb
  begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_bv = bv_ff;
    nxt_rv = rv_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_bresp = bresp_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw = 1'b1;
      nxt_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w = 1'b1;
      nxt_wr_data = s_axi_wdata;
    end
    known_wr = wr_addr_ff inside {REG_STATUS, REG_INSEL, REG_ROLE, REG_PATH, REG_LOOP, REG_MODE};
    wr_go = aw_ff && w_ff && !bv_ff;
    if (wr_go)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_bresp = known_wr ? AXI_OKAY : AXI_SLVERR;
    end
    if (bv_ff && s_axi_bready)
      nxt_bv = 1'b0;
    known_rd = s_axi_araddr inside {REG_STATUS, REG_INSEL, REG_ROLE, REG_PATH, REG_LOOP, REG_MODE};
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rv = 1'b1;
      nxt_rresp = known_rd ? AXI_OKAY : AXI_SLVERR;
      nxt_rdata = 32'h0;
      case (s_axi_araddr)
        REG_STATUS: nxt_rdata = {29'h0, family_ff, role_pin_s, 1'b0};
        REG_INSEL: nxt_rdata = {27'h0, fast_en_ff, 4'h0};
        REG_ROLE: nxt_rdata = {31'h0, role_ctrl_ff};
        REG_PATH: nxt_rdata = {15'h0, follow_ff, scfg_ff, pcfg_ff};
        REG_LOOP: nxt_rdata = {5'h0, cal_ff, 5'h0, damp_ff, 3'h0, bw_ff};
        REG_MODE: nxt_rdata = {14'h0, ready_ff, absorb_ff, ssrc, psrc, 2'h0, smode_ff, pmode_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
    else if (rv_ff && s_axi_rready)
      nxt_rv = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
      bresp_ff <= AXI_OKAY;
      rresp_ff <= AXI_OKAY;
      rdata_ff <= '0;
    end
    else
    begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      bv_ff <= nxt_bv;
      rv_ff <= nxt_rv;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Bus handshakes and outputs
  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready = !w_ff && !bv_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign dev_ready = ready_ff;
  assign is_master = master_ff;
  assign primary_src = psrc_ff;
  assign secondary_src = ssrc_ff;
  assign primary_mode = pmode_ff;
  assign secondary_mode = smode_ff;
  assign secondary_follow = follow_ff;
  assign phase_absorb = absorb_ff;
  assign pbo_event = pbo_ff;
  assign sync8k_out = s8_ff;
  assign sync2k_out = s2_ff;
endmodule : timing_strap_reset_mode_ctrl

// file: verif/strap_ctrl_properties.sv
`timescale 1ns/100ps
// Watches reset hold, bus answers and pulse outputs at the top ports
module strap_ctrl_properties
  import strap_ctrl_pkg::*;
#(
  parameter int HOLD_CYCLES = 20 // Internal hold after release
)
(
  input wire logic clock, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic frame_sync_in, // Sync input
  input wire logic phase_jump_pin, // Phase step seen
  input wire logic dev_ready, // Internal reset over
  input wire logic [2:0] primary_mode, // Primary mode
  input wire logic [2:0] secondary_mode, // Secondary mode
  input wire logic sync8k_out, // 8 kHz pulse
  input wire logic phase_absorb, // Absorb pulse
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready // Write response ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [31:0] up_cnt_ff; // Cycles since reset release
  logic [31:0] nxt_up_cnt; // Saturating next count
  // Count up, stop at the top value
  always_comb nxt_up_cnt = (up_cnt_ff == 32'hffffffff) ? up_cnt_ff : up_cnt_ff + 32'h1;
  // Register the count
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      up_cnt_ff <= 32'h0;
    else
      up_cnt_ff <= nxt_up_cnt;
  end
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  property p_ready_late;
    $rose(dev_ready) |-> up_cnt_ff >= HOLD_CYCLES;
  endproperty
  property p_ready_stays;
    dev_ready |=> dev_ready;
  endproperty
  property p_modes;
    $onehot(primary_mode) && $onehot(secondary_mode);
  endproperty
  property p_ar_answer;
    s_ar_taken |=> s_axi_rvalid;
  endproperty
  property p_r_stands;
    s_r_waiting |=> s_axi_rvalid;
  endproperty
  property p_ar_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_sync_pulse;
    sync8k_out |=> !sync8k_out;
  endproperty
  property p_sync_quiet;
    !frame_sync_in [*6] |-> !sync8k_out;
  endproperty
  property p_absorb_pulse;
    phase_absorb |=> !phase_absorb;
  endproperty
  property p_absorb_quiet;
    !phase_jump_pin [*7] |-> !phase_absorb;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  a_ready_stays: assert property (p_ready_stays) else $error("ready dropped");
  a_modes: assert property (p_modes) else $error("mode not one-hot");
  a_ar_answer: assert property (p_ar_answer) else $error("no read answer");
  a_r_stands: assert property (p_r_stands) else $error("rvalid dropped");
  a_ar_refused: assert property (p_ar_refused) else $error("arready with rvalid");
  a_b_stands: assert property (p_b_stands) else $error("bvalid dropped");
  a_sync_pulse: assert property (p_sync_pulse) else $error("8k pulse too long");
  a_sync_quiet: assert property (p_sync_quiet) else $error("8k pulse without edge");
  a_absorb_pulse: assert property (p_absorb_pulse) else $error("absorb too long");
  a_absorb_quiet: assert property (p_absorb_quiet) else $error("absorb without jump");
endmodule : strap_ctrl_properties

bind timing_strap_reset_mode_ctrl strap_ctrl_properties #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.clock, .nrst,
  .frame_sync_in, .phase_jump_pin, .dev_ready, .primary_mode, .secondary_mode, .sync8k_out, .phase_absorb,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);

// file: verif/board_model.sv
`timescale 1ns/100ps
// Board side: reset source and strap pins
module board_model
(
  input wire logic clock, // Clock
  input wire logic rst_req, // Start a reset pulse
  input wire logic [2:0] strap_lvl, // Fast, role, family levels
  output logic nrst, // Reset pin, active low
  output logic fast_ref_select_pin, // Fast select strap
  output logic role_select_pin, // Role pin
  output logic freq_family_pin // Family strap
);
  logic [3:0] low_cnt = 4'h6; // Cycles of reset left
  // Reset low until the count runs out
  assign nrst = (low_cnt == 4'h0);
  // Pins change just after the edge
  always @(posedge clock)
  begin
    if (rst_req)
      low_cnt <= 4'h6;
    else if (low_cnt != 4'h0)
      low_cnt <= low_cnt - 4'h1;
    {fast_ref_select_pin, role_select_pin, freq_family_pin} <= strap_lvl;
  end
endmodule : board_model

// file: verif/testbench.sv
`timescale 1ns/100ps
// Self-checking bench for the strap, role and mode control
module testbench;
  import strap_ctrl_pkg::*;
  logic clock = 1'b0, rst_req = 1'b0, phase_jump_pin = 1'b0, frame_sync_in = 1'b0;
  logic [2:0] strap_lvl = 3'b101; // Fast high, role low, family high
  logic [13:0] ref_valid_pins = 14'h0;
  logic nrst, fast_ref_select_pin, role_select_pin, freq_family_pin, dev_ready, is_master;
  logic [3:0] primary_src, secondary_src;
  logic [2:0] primary_mode, secondary_mode;
  logic secondary_follow, phase_absorb, pbo_event, sync8k_out, sync2k_out;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int num_errors = 0, comparisons = 0, n8k = 0, n2k = 0, n_abs = 0, n_pbo = 0, base;
  // Clock at 40 MHz
  always #12.5 clock = ~clock;
  board_model board (.clock, .rst_req, .strap_lvl, .nrst, .fast_ref_select_pin, .role_select_pin, .freq_family_pin);
  timing_strap_reset_mode_ctrl #(.HOLD_CYCLES(20), .PHASE_WIN_CYCLES(10)) uut (.clock, .nrst,
    .fast_ref_select_pin, .role_select_pin, .freq_family_pin, .ref_valid_pins, .phase_jump_pin, .frame_sync_in,
    .dev_ready, .is_master, .primary_src, .secondary_src, .primary_mode, .secondary_mode, .secondary_follow,
    .phase_absorb, .pbo_event, .sync8k_out, .sync2k_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Count output pulses
  always @(posedge clock)
  begin
    n8k <= n8k + int'(sync8k_out === 1'b1);
    n2k <= n2k + int'(sync2k_out === 1'b1);
    n_abs <= n_abs + int'(phase_absorb === 1'b1);
    n_pbo <= n_pbo + int'(pbo_event === 1'b1);
  end
  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle;
    repeat (8) @(posedge clock);
  endtask : settle
  // Bus write; response ready held until bvalid is seen
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50)
    begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, AXI_OKAY);
        n = 99;
      end
    end
    if (n == 50)
    begin
      num_errors++;
      report_and_stop;
    end
    // Let an edge pass so the next call does not re-raise ready at once
    @(posedge clock);
  endtask : axi_write
  // Bus read; data ready held until rvalid is seen
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50)
    begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        n = 99;
      end
    end
    if (n == 50)
    begin
      num_errors++;
      report_and_stop;
    end
    // Let an edge pass so the next call does not re-raise ready at once
    @(posedge clock);
  endtask : axi_read
  // Straps captured at reset, later pin changes
  task automatic t_straps;
    chk(primary_src, 4'h3);
    axi_read(REG_INSEL, rd, rr);
    chk(rd[B_FAST_EN], 1'b1);
    axi_read(REG_STATUS, rd, rr);
    chk(rd[2:1], 2'b10);
    strap_lvl <= 3'b010;
    settle;
    chk(primary_src, 4'h4);
    axi_read(REG_STATUS, rd, rr);
    chk(rd[2:1], 2'b11);
  endtask : t_straps
  // All four pin and control bit pairs
  task automatic t_role;
    for (int i = 0; i < 4; i++)
    begin
      strap_lvl <= {1'b0, i[1], 1'b0};
      axi_write(REG_ROLE, {31'h0, i[0]});
      settle;
      chk(is_master, i[1] ^ i[0]);
    end
  endtask : t_role
  // Fast select off: pin ignored, lowest good input wins
  task automatic t_fast_off;
    axi_write(REG_INSEL, 32'h0);
    ref_valid_pins <= 14'h0006;
    for (int i = 0; i < 2; i++)
    begin
      strap_lvl <= {i[0], 2'b00};
      settle;
      chk(primary_src, 4'h2);
    end
  endtask : t_fast_off
  // Forced modes, manual sources, follow and build-out
  task automatic t_path;
    logic [7:0] cfg [3] = '{8'ha0, 8'hc0, 8'h80};
    logic [2:0] mode [3] = '{M_LOCK, M_HOLD, M_FREE};
    for (int i = 0; i < 3; i++)
    begin
      axi_write(REG_PATH, {16'h0001, 8'h16, cfg[i]});
      settle;
      chk(primary_mode, mode[i]);
    end
    chk(secondary_src, 4'h6);
    chk(secondary_follow, 1'b1);
    chk(secondary_mode, M_LOCK);
    base = n_pbo;
    axi_write(REG_PATH, 32'h00011616);
    settle;
    chk(primary_src, 4'h6);
    chk(primary_mode, M_HOLD);
    chk(n_pbo - base, 1);
  endtask : t_path
  // Loop settings range and an unmapped place
  task automatic t_loop;
    axi_write(REG_LOOP, 32'h00000412);
    axi_write(REG_LOOP, 32'h00000513);
    axi_read(REG_LOOP, rd, rr);
    chk(rd & 32'h0000071f, 32'h00000412);
    axi_read(8'hfc, rd, rr);
    chk(rr, AXI_SLVERR);
    chk(rd, 32'h0);
  endtask : t_loop
  // Four sync edges give four 8k pulses and one 2k pulse
  task automatic t_sync;
    base = n8k;
    for (int i = 0; i < 4; i++)
    begin
      frame_sync_in <= 1'b1;
      repeat (3) @(posedge clock);
      frame_sync_in <= 1'b0;
      repeat (5) @(posedge clock);
    end
    settle;
    chk(n8k - base, 4);
    chk(n2k, 1);
  endtask : t_sync
  task automatic jump(input int gap);
    phase_jump_pin <= 1'b1;
    repeat (2) @(posedge clock);
    phase_jump_pin <= 1'b0;
    repeat (gap) @(posedge clock);
  endtask : jump
  // Jumps far apart are left alone, close ones absorbed
  task automatic t_phase;
    jump(15);
    jump(4);
    chk(n_abs, 0);
    jump(4);
    settle;
    chk(n_abs, 1);
  endtask : t_phase
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    for (int n = 0; n < 200 && dev_ready !== 1'b1; n++) @(posedge clock);
    chk(dev_ready, 1'b1);
    t_straps;
    t_role;
    t_fast_off;
    t_path;
    t_loop;
    t_sync;
    t_phase;
    report_and_stop;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    report_and_stop;
  end
endmodule : testbench
